// >>> hw/sid_pkg.sv
// shared constants and carrier types of the self-identity receive dma
package sid_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses, one aligned word each)
   localparam logic [7:0] SID_OFF_BASE = 8'h00;
   localparam logic [7:0] SID_OFF_COUNT = 8'h04;
   localparam logic [7:0] SID_OFF_CTRL_SET = 8'h08;
   localparam logic [7:0] SID_OFF_CTRL_CLR = 8'h0c;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int SID_BASE_LSB = 11;
   localparam int SID_CNT_FAULT_BIT = 31;
   localparam int SID_CNT_GEN_LSB = 16;
   localparam int SID_CNT_SIZE_LSB = 2;
   localparam int SID_CTRL_ACCEPT_BIT = 0;
   localparam int SID_CTRL_PHASE_BIT = 1;
   localparam int SID_HDR_GEN_LSB = 16;
   localparam int SID_SEC_BITS = 3;
   localparam int SID_CYC_BITS = 13;

   ////////////////////////////////////////////////////////////////////////////
   // widths, reset values and limits
   localparam int SID_GEN_W = 8;
   localparam int SID_SIZE_W = 9;
   localparam logic [SID_GEN_W-1:0] SID_GEN_RST = 8'h00;
   localparam logic [SID_SIZE_W-1:0] SID_SIZE_RST = 9'h000;
   // full marker is all ones of the nine-bit size field
   localparam logic [SID_SIZE_W-1:0] SID_SIZE_FULL = 9'h1ff;
   localparam logic SID_ACCEPT_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] data;
   } sid_rx_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } sid_wr_t;

   typedef enum logic [1:0] {
      SID_ST_IDLE = 2'b00,
      SID_ST_HEADER = 2'b01,
      SID_ST_RECV = 2'b10,
      SID_ST_HOLD = 2'b11
   } sid_state_t;

endpackage

// >>> hw/sid_gen_counter.sv
// wrapping generation counter
`timescale 1ns/100ps
module sid_gen_counter
   import sid_pkg::*;
#(
   parameter int W = SID_GEN_W
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic inc_i,
   output logic [W-1:0] count_o
);

   logic [W-1:0] count_q;

   // natural overflow gives the wrap to zero
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         count_q <= W'(SID_GEN_RST);
      end else if (inc_i) begin
         count_q <= count_q + W'(1); // [R3]
      end
   end

   assign count_o = count_q;

endmodule

// >>> hw/sid_wr_port.sv
// one-entry host memory write stage with overrun report
`timescale 1ns/100ps
module sid_wr_port
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire sid_wr_t in_i,
   output logic in_ready_o,
   output logic wr_valid_o,
   output sid_wr_t wr_o,
   input wire logic wr_ready_i,
   output logic overrun_o
);

   logic busy_q;
   sid_wr_t hold_q;

   // link data cannot wait, so a full stage means lost data
   assign in_ready_o = !busy_q || wr_ready_i;
   assign overrun_o = in_valid_i && !in_ready_o;
   assign wr_valid_o = busy_q;
   assign wr_o = hold_q;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
      end else if (in_valid_i && in_ready_o) begin
         busy_q <= 1'b1;
      end else if (wr_ready_i) begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         hold_q <= '0;
      end else if (in_valid_i && in_ready_o) begin
         hold_q <= in_i;
      end
   end

endmodule

// >>> hw/sid_dma.sv
// self-identity receive dma: apb registers, capture sequencer, memory writes
`timescale 1ns/100ps

// Functional notes
// [R1] base register holds 2K-aligned buffer address; not reset.
// [R2] fault flag set on receive or memory write error; cleared after clean reception.
// [R3] 8-bit generation counter increments per bus reset, wraps 255 to 0.
// [R4] stored count gives quadlets written this generation, header included.
// [R5] bus reset clears stored count in the same cycle as reset event.
// [R6] first buffer quadlet carries the generation value.
// [R7] bus reset mid-sequence restarts writing at buffer start, overwriting.
// [R8] after fault in a sequence, further data is dropped.
// [R9] 2048 bytes received forces count to full value and sets fault.
// [R10] no integrity check; data and inverted quadlets both stored.
// [R11] after header, all quadlets from reset end to subaction gap stored.
// [R12] header timestamp is seconds low three bits and 13-bit cycle count.
// [R13] software loads base before enabling packet acceptance.
// [R14] phase-done event pulses when self-identity phase ends.
// [R15] self-identity quadlets outside the phase go to async request path; code routes only in idle, quadlets arriving in hold are dropped.
// [R16] software checks generation in memory against count register.
// [R17] quadlet address is base plus four times stored count.
module sid_dma
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic bus_reset_i,
   input wire logic reset_end_i,
   input wire logic subaction_gap_i,
   input wire sid_rx_t rx_i,
   input wire logic [SID_SEC_BITS-1:0] second_counter_i,
   input wire logic [SID_CYC_BITS-1:0] cycle_in_second_counter_i,
   output logic wr_valid_o,
   output sid_wr_t wr_o,
   input wire logic wr_ready_i,
   input wire logic wr_err_i,
   output logic ar_valid_o,
   output logic [31:0] ar_data_o,
   output logic bus_reset_event_o,
   output logic identity_phase_done_event_o
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [31:SID_BASE_LSB] identity_buffer_base_field;
   logic accept_identity_packets;
   logic identity_fault_flag;
   logic [SID_SIZE_W-1:0] stored_quadlet_count;
   logic [SID_GEN_W-1:0] reset_generation_counter;
   sid_state_t state_q;
   sid_state_t state_d;
   logic seq_err_q;
   logic in_phase;
   logic apb_wr;
   logic apb_rd;
   logic hit;
   logic [31:0] rd_data;
   logic q_valid;
   sid_wr_t q_wr;
   logic q_ready;
   logic q_overrun;
   logic q_take;
   logic store_rx;
   logic store_hdr;
   logic full_hit;
   logic err_now;
   logic rx_overrun;
   logic rx_fault;
   logic phase_end;
   logic route_ar;
   logic [31:0] header_word;
   logic [31:0] ar_data_q;
   logic ar_valid_q;
   logic bus_reset_ev_q;
   logic phase_done_ev_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, unmapped addresses answer with an error

   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign apb_rd = psel_i && !pwrite_i;
   assign pready_o = 1'b1;

   always_comb begin
      hit = 1'b1;
      rd_data = 32'h0000_0000;
      case (paddr_i)
         SID_OFF_BASE: begin
            rd_data[31:SID_BASE_LSB] = identity_buffer_base_field;
         end
         SID_OFF_COUNT: begin
            rd_data[SID_CNT_FAULT_BIT] = identity_fault_flag;
            rd_data[SID_CNT_GEN_LSB +: SID_GEN_W] = reset_generation_counter;
            rd_data[SID_CNT_SIZE_LSB +: SID_SIZE_W] = stored_quadlet_count;
         end
         SID_OFF_CTRL_SET, SID_OFF_CTRL_CLR: begin
            rd_data[SID_CTRL_ACCEPT_BIT] = accept_identity_packets;
            rd_data[SID_CTRL_PHASE_BIT] = in_phase;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // writes to the read-only count are ignored, not refused
   assign pslverr_o = psel_i && penable_i && !hit;

   // read data registered so it stands through the access phase
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (apb_rd && !penable_i) begin
         prdata_o <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer base: deliberately left without reset value

   always_ff @(posedge clock_i) begin
      if (apb_wr && paddr_i == SID_OFF_BASE) begin
         identity_buffer_base_field <= pwdata_i[31:SID_BASE_LSB]; // [R1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link control set/clear pair; only the accept bit is stored here, bit 1 reads back the phase

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         accept_identity_packets <= SID_ACCEPT_RST;
      end else if (apb_wr && paddr_i == SID_OFF_CTRL_SET && pwdata_i[SID_CTRL_ACCEPT_BIT]) begin
         // base must already be valid here; hardware does not check it
         accept_identity_packets <= 1'b1; // [R13]
      end else if (apb_wr && paddr_i == SID_OFF_CTRL_CLR && pwdata_i[SID_CTRL_ACCEPT_BIT]) begin
         accept_identity_packets <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // generation counter

   sid_gen_counter #(
      .W(SID_GEN_W)
   ) u_gen (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .inc_i(bus_reset_i), // [R3]
      .count_o(reset_generation_counter)
   );

   ////////////////////////////////////////////////////////////////////////////
   // capture sequencer
   // idle: waiting for reset end; header: emit header quadlet;
   // recv: storing packets until the gap; hold: reset seen, waiting for its end

   assign in_phase = (state_q == SID_ST_HEADER) || (state_q == SID_ST_RECV);

   // header moves on once the stage is ready for it or the sequence is already spoilt
   always_comb begin
      state_d = state_q;
      case (state_q)
         SID_ST_IDLE: begin
            if (reset_end_i) begin
               state_d = SID_ST_HEADER;
            end
         end
         SID_ST_HEADER: begin
            if (subaction_gap_i) begin
               state_d = SID_ST_IDLE;
            end else if (q_ready || seq_err_q) begin
               state_d = SID_ST_RECV;
            end
         end
         SID_ST_RECV: begin
            if (subaction_gap_i) begin
               state_d = SID_ST_IDLE; // [R11]
            end
         end
         SID_ST_HOLD: begin
            if (reset_end_i) begin
               state_d = SID_ST_HEADER;
            end
         end
         default: begin
            state_d = SID_ST_IDLE;
         end
      endcase
      // a new reset always wins and restarts the sequence
      if (bus_reset_i) begin
         state_d = SID_ST_HOLD; // [R7]
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_q <= SID_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // what gets stored

   // timestamp sampled in the very cycle the header enters the write stage
   assign header_word = {8'h00, reset_generation_counter,
                         second_counter_i, cycle_in_second_counter_i}; // [R6] [R12]

   // with acceptance off the phase still runs but nothing is written
   assign store_hdr = (state_q == SID_ST_HEADER) && accept_identity_packets
                      && !seq_err_q && !bus_reset_i;
   // raw quadlets, inverted check words included, no checking done
   assign store_rx = (state_q == SID_ST_RECV) && rx_i.valid && accept_identity_packets
                     && !seq_err_q && !bus_reset_i; // [R8] [R10] [R11]

   assign q_valid = store_hdr || store_rx;
   assign q_take = q_valid && q_ready;
   assign q_wr.addr = {identity_buffer_base_field, stored_quadlet_count, 2'b00}; // [R17]
   assign q_wr.data = store_hdr ? header_word : rx_i.data;

   // the last quadlet of a full 2048-byte buffer
   assign full_hit = store_rx && q_take && (stored_quadlet_count == SID_SIZE_FULL); // [R9]

   // a header waiting for a free stage loses nothing; only link quadlets overrun
   assign rx_overrun = q_overrun && store_rx;
   assign rx_fault = in_phase && rx_i.valid && rx_i.err;
   assign err_now = rx_fault || wr_err_i || rx_overrun || full_hit;

   sid_wr_port u_wr (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(q_valid),
      .in_i(q_wr),
      .in_ready_o(q_ready),
      .wr_valid_o(wr_valid_o),
      .wr_o(wr_o),
      .wr_ready_i(wr_ready_i),
      .overrun_o(q_overrun)
   );

   ////////////////////////////////////////////////////////////////////////////
   // stored quadlet count
   // the full marker stays until the next bus reset

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         stored_quadlet_count <= SID_SIZE_RST;
      end else if (bus_reset_i) begin
         stored_quadlet_count <= SID_SIZE_RST; // [R5]
      end else if (full_hit) begin
         stored_quadlet_count <= SID_SIZE_FULL; // [R9]
      end else if (q_take) begin
         stored_quadlet_count <= stored_quadlet_count + 9'h001; // [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error tracking

   // a reset in the same cycle cancels the end of the phase
   assign phase_end = in_phase && subaction_gap_i && !bus_reset_i;

   // per-sequence error, restarted by each reset
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         seq_err_q <= 1'b0;
      end else if (bus_reset_i) begin
         seq_err_q <= 1'b0;
      end else if (err_now) begin
         seq_err_q <= 1'b1; // [R8]
      end
   end

   // visible flag: set at once, cleared only when a clean sequence ends
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         identity_fault_flag <= 1'b0;
      end else if (err_now) begin
         identity_fault_flag <= 1'b1; // [R2] [R9]
      end else if (phase_end && !seq_err_q && accept_identity_packets) begin
         identity_fault_flag <= 1'b0; // [R2]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // packets outside the phase go to the async request receive path
   // hold is still part of initialization, so only idle routes
   assign route_ar = rx_i.valid && (state_q == SID_ST_IDLE);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ar_valid_q <= 1'b0;
      end else begin
         ar_valid_q <= route_ar; // [R15]
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ar_data_q <= 32'h0000_0000;
      end else if (route_ar) begin
         ar_data_q <= rx_i.data; // [R15]
      end
   end

   assign ar_valid_o = ar_valid_q;
   assign ar_data_o = ar_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // event pulses

   // registered on the same edge that clears the count
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bus_reset_ev_q <= 1'b0;
      end else begin
         bus_reset_ev_q <= bus_reset_i; // [R5]
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         phase_done_ev_q <= 1'b0;
      end else begin
         phase_done_ev_q <= phase_end; // [R14]
      end
   end

   assign bus_reset_event_o = bus_reset_ev_q;
   assign identity_phase_done_event_o = phase_done_ev_q;

endmodule

// >>> verification/sid_dma_asserts.sv
// port checker for the self-identity receive dma
`timescale 1ns/100ps
module sid_dma_asserts
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic bus_reset_i,
   input wire logic reset_end_i,
   input wire logic subaction_gap_i,
   input wire sid_rx_t rx_i,
   input wire logic [SID_SEC_BITS-1:0] second_counter_i,
   input wire logic [SID_CYC_BITS-1:0] cycle_in_second_counter_i,
   input wire logic wr_valid_o,
   input wire sid_wr_t wr_o,
   input wire logic wr_ready_i,
   input wire logic ar_valid_o,
   input wire logic [31:0] ar_data_o,
   input wire logic bus_reset_event_o,
   input wire logic identity_phase_done_event_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic in_phase_q;
   logic [7:0] gen_q;
   logic [31:0] base_q;
   logic accept_q;
   logic ctrl_wr;
   assign ctrl_wr = psel_i && penable_i && pwrite_i && pwdata_i[SID_CTRL_ACCEPT_BIT];
   ////////////////////////////////////////////////////////////
   // shadows rebuilt from the ports only
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) in_phase_q <= 1'b0;
      else if (bus_reset_i || subaction_gap_i) in_phase_q <= 1'b0;
      else if (reset_end_i) in_phase_q <= 1'b1;
   end
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) gen_q <= 8'h00;
      else if (bus_reset_i) gen_q <= gen_q + 8'h01;
   end
   // base is not reset, so the shadow is not either
   always_ff @(posedge clock_i) begin
      if (psel_i && penable_i && pwrite_i && paddr_i == SID_OFF_BASE) base_q <= pwdata_i;
   end
   // nothing is stored while acceptance is off
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) accept_q <= 1'b0;
      else if (ctrl_wr && paddr_i == SID_OFF_CTRL_SET) accept_q <= 1'b1;
      else if (ctrl_wr && paddr_i == SID_OFF_CTRL_CLR) accept_q <= 1'b0;
   end
   sequence hdr_s;
      reset_end_i ##1 !bus_reset_i && accept_q;
   endsequence
   ////////////////////////////////////////////////////////////
   ready_const_a: assert property (pready_o)
      else $error("pready low");
   reset_event_a: assert property (bus_reset_i |=> bus_reset_event_o)
      else $error("no reset event");
   event_cause_a: assert property (bus_reset_event_o |-> $past(bus_reset_i))
      else $error("spurious reset event");
   write_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o))
      else $error("write dropped while stalled");
   buffer_window_a: assert property (wr_valid_o |-> wr_o.addr[31:11] == base_q[31:11])
      else $error("write outside buffer");
   header_quad_a: assert property (hdr_s |=> wr_valid_o
      && wr_o.addr == {base_q[31:11], 11'h000} && wr_o.data == {8'h00, gen_q,
      $past(second_counter_i), $past(cycle_in_second_counter_i)})
      else $error("bad header write");
   phase_done_a: assert property (subaction_gap_i && in_phase_q && !bus_reset_i |=>
      identity_phase_done_event_o ##1 !identity_phase_done_event_o)
      else $error("phase done event wrong");
   async_route_a: assert property (rx_i.valid && !in_phase_q && !bus_reset_i
      |=> ar_valid_o && ar_data_o == $past(rx_i.data))
      else $error("quadlet not routed");
endmodule

bind sid_dma sid_dma_asserts u_sid_dma_asserts (.clock_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .bus_reset_i, .reset_end_i, .subaction_gap_i,
   .rx_i, .second_counter_i, .cycle_in_second_counter_i, .wr_valid_o, .wr_o, .wr_ready_i,
   .ar_valid_o, .ar_data_o, .bus_reset_event_o, .identity_phase_done_event_o);

// >>> verification/sid_mem_model.sv
// host memory model: stores writes, may stall or report a write error
`timescale 1ns/100ps
module sid_mem_model
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic wr_valid_i,
   input wire sid_wr_t wr_i,
   input wire logic stall_i,
   input wire logic fail_i,
   output logic wr_ready_o,
   output logic wr_err_o
);
   logic [31:0] mem [logic [31:0]];
   assign wr_ready_o = !stall_i;
   // error reported one cycle after the failing write, like a posted bus
   always @(posedge clock_i) begin
      wr_err_o <= 1'b0;
      if (wr_valid_i && wr_ready_o) begin
         mem[wr_i.addr] = wr_i.data;
         wr_err_o <= fail_i;
      end
   end
endmodule

// >>> verification/self_identity_receive_dma_tb_top.sv
// self-checking bench for the self-identity receive dma
`timescale 1ns/100ps
module self_identity_receive_dma_tb_top;
   import sid_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic brst = 1'b0, rend = 1'b0, gap = 1'b0, stall = 1'b0, fail = 1'b0;
   logic pready, pslverr, wr_valid, wr_ready, wr_err, ar_valid, bre, pde, perr;
   logic [7:0] paddr = 8'h00;
   logic [7:0] g = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, ar_data, rd;
   logic [31:0] base = 32'h0004_0800;
   logic [2:0] sec = 3'h0;
   logic [12:0] cyc = 13'h0000;
   sid_rx_t rx = '0;
   sid_wr_t wr;
   int miscompares = 0, comparisons = 0, nbre = 0, npde = 0;

   initial begin
      forever #25 clk = ~clk;
   end

   sid_dma u_sid_dma (.clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .bus_reset_i(brst), .reset_end_i(rend),
      .subaction_gap_i(gap), .rx_i(rx), .second_counter_i(sec),
      .cycle_in_second_counter_i(cyc), .wr_valid_o(wr_valid), .wr_o(wr),
      .wr_ready_i(wr_ready), .wr_err_i(wr_err), .ar_valid_o(ar_valid), .ar_data_o(ar_data),
      .bus_reset_event_o(bre), .identity_phase_done_event_o(pde));

   sid_mem_model u_sid_mem_model (.clock_i(clk), .wr_valid_i(wr_valid), .wr_i(wr),
      .stall_i(stall), .fail_i(fail), .wr_ready_o(wr_ready), .wr_err_o(wr_err));

   always @(posedge clk) begin
      nbre <= nbre + int'(bre);
      npde <= npde + int'(pde);
   end
   ////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // 0 bus reset, 1 reset end, 2 subaction gap
   task pulse(input int k);
      @(posedge clk);
      case (k)
         0: brst <= 1'b1;
         1: rend <= 1'b1;
         default: gap <= 1'b1;
      endcase
      @(posedge clk);
      {brst, rend, gap} <= 3'b000;
      if (k == 0) g = g + 8'h01;
   endtask

   function automatic logic [31:0] pat(input int i);
      logic [31:0] v;
      v = {8'h5c, g, 16'(i / 2)};
      return (i % 2) ? ~v : v;
   endfunction

   task quad(input logic [31:0] d, input logic e);
      @(posedge clk);
      rx <= '{valid: 1'b1, err: e, data: d};
      @(posedge clk);
      rx <= '0;
   endtask

   // quadlets spaced two cycles so a free stage never overruns
   task seq(input int n, input logic e);
      pulse(0);
      sec <= g[2:0];
      cyc <= {5'h0a, g};
      pulse(1);
      repeat (2) @(posedge clk);
      for (int i = 0; i < n; i++) quad(pat(i), e && i == 0);
      pulse(2);
      repeat (4) @(posedge clk);
   endtask

   task verify(input logic f, input logic [8:0] sz);
      apb(1'b0, SID_OFF_COUNT, 32'h0);
      chk("count", {f, 7'h00, g, 5'h00, sz, 2'b00}, rd);
   endtask

   task mem_ok(input int n);
      chk("header", {8'h00, g, sec, cyc}, u_sid_mem_model.mem[base]);
      for (int i = 0; i < n; i++) begin
         chk("quad", pat(i), u_sid_mem_model.mem[base + 32'(4 * i + 4)]);
      end
   endtask

   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done;
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      verify(1'b0, 9'h000);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, perr});
      apb(1'b1, SID_OFF_BASE, base | 32'h0000_07ff);
      apb(1'b0, SID_OFF_BASE, 32'h0);
      chk("base", base, rd);
      apb(1'b1, SID_OFF_COUNT, 32'hffff_ffff);
      verify(1'b0, 9'h000);
      apb(1'b1, SID_OFF_CTRL_SET, 32'h1);
      apb(1'b0, SID_OFF_CTRL_CLR, 32'h0);
      chk("accept", 32'h1, rd);
      seq(4, 1'b0);
      verify(1'b0, 9'h005);
      mem_ok(4);
      quad(32'h0bad_cafe, 1'b0);
      #1 chk("ar valid", 32'h1, {31'h0, ar_valid});
      chk("ar data", 32'h0bad_cafe, ar_data);
      seq(4, 1'b1);
      apb(1'b0, SID_OFF_COUNT, 32'h0);
      chk("rx fault", 32'h1, {31'h0, rd[31]});
      chk("dropped", 32'h1, {31'h0, rd[10:2] < 9'h005});
      stall <= 1'b1;
      seq(2, 1'b0);
      stall <= 1'b0;
      repeat (3) @(posedge clk);
      verify(1'b1, 9'h001);
      fail <= 1'b1;
      seq(2, 1'b0);
      fail <= 1'b0;
      apb(1'b0, SID_OFF_COUNT, 32'h0);
      chk("write fault", 32'h1, {31'h0, rd[31]});
      seq(3, 1'b0);
      verify(1'b0, 9'h004);
      mem_ok(3);
      // acceptance off: the phase runs but nothing is stored
      apb(1'b1, SID_OFF_CTRL_CLR, 32'h1);
      apb(1'b0, SID_OFF_CTRL_SET, 32'h0);
      chk("accept off", 32'h0, rd);
      seq(2, 1'b0);
      verify(1'b0, 9'h000);
      apb(1'b1, SID_OFF_CTRL_SET, 32'h1);
      seq(520, 1'b0);
      verify(1'b1, SID_SIZE_FULL);
      chk("last quad", pat(510), u_sid_mem_model.mem[base + 32'h0000_07fc]);
      for (int i = 0; i < 256; i++) pulse(0);
      apb(1'b0, SID_OFF_COUNT, 32'h0);
      chk("generation", {24'h0, g}, {24'h0, rd[23:16]});
      chk("size cleared", 32'h0, {23'h0, rd[10:2]});
      chk("reset events", 32'h0000_0107, 32'(nbre));
      chk("phase events", 32'h7, 32'(npde));
      test_done;
   end
endmodule
